// ==== common/prescaler_if.sv ====
/*
 * Carrier between a timer channel and its prescaler.
 * Assumes edge pulses are already synchronised to clk.
 */
interface prescaler_if;
   logic [2:0] sel;
   logic restart;
   logic extFall;
   logic xtalFall;
   logic tick;
   modport owner (output sel, restart, extFall, xtalFall, input tick);
   modport presc (input sel, restart, extFall, xtalFall, output tick);
endinterface

// ==== common/timer_pkg.sv ====
/*
 * Constants for the two-channel multimode down timer: register offsets,
 * field positions, reset values, clock/mode codes and time-base periods.
 * Assumes a 50 MHz system clock.
 */
package timer_pkg;
   // register offsets (5-bit address)
   localparam logic [4:0] ADDR_STATUS = 5'h00;
   localparam logic [4:0] ADDR_CTRL0 = 5'h01;
   localparam logic [4:0] ADDR_CTRL1 = 5'h02;
   localparam logic [4:0] ADDR_OUTCFG = 5'h02;
   localparam logic [4:0] ADDR_INTEN = 5'h03;
   localparam logic [4:0] ADDR_ROUTE = 5'h04;
   localparam logic [4:0] ADDR_T0_LO = 5'h0F;
   localparam logic [4:0] ADDR_T0_HI = 5'h10;
   localparam logic [4:0] ADDR_T1_LO = 5'h11;
   localparam logic [4:0] ADDR_T1_HI = 5'h12;
   // status register fields
   localparam int STAT_FLAG0 = 0;
   localparam int STAT_FLAG1 = 1;
   localparam int STAT_RSEL = 6;
   localparam int STAT_PSEL = 7;
   // timer control fields
   localparam int CTL_RUN = 0;
   localparam int CTL_MODE_LO = 1;
   localparam int CTL_MODE_HI = 2;
   localparam int CTL_CLK_LO = 3;
   localparam int CTL_CLK_HI = 5;
   localparam int CTL_READ = 6;
   localparam int CTL_HOLD = 7;
   // output config fields: invert and open drain per pin
   localparam int OC_INV0 = 0;
   localparam int OC_OD0 = 1;
   localparam int OC_INV1 = 2;
   localparam int OC_OD1 = 3;
   localparam int OC_INVI = 4;
   localparam int OC_ODI = 5;
   // routing field: timer interrupts reach the interrupt pin
   localparam int RT_TIMER = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // clock select codes
   localparam logic [2:0] CLK_EXT = 3'h0;
   localparam logic [2:0] CLK_XTAL = 3'h1;
   localparam logic [2:0] CLK_XTAL4 = 3'h2;
   localparam logic [2:0] CLK_10K7 = 3'h3;
   localparam logic [2:0] CLK_1K = 3'h4;
   localparam logic [2:0] CLK_100 = 3'h5;
   localparam logic [2:0] CLK_10 = 3'h6;
   localparam logic [2:0] CLK_1 = 3'h7;
   // mode codes
   localparam logic [1:0] MODE_PULSE = 2'h0;
   localparam logic [1:0] MODE_RATE = 2'h1;
   localparam logic [1:0] MODE_SQUARE = 2'h2;
   localparam logic [1:0] MODE_ONESHOT = 2'h3;
   // time bases
   localparam int CLK_PERIOD_NS = 20;
   localparam int BASE_PERIOD_NS = 93500;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int BASE_CYC = BASE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MS_CYC = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [3:0] DECADE_LAST = 4'h9;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARM = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_COUNT = 4'b1000
   } tstate_t;
endpackage

// ==== tb/host_bus_model.sv ====
/*
 * Host processor model on the byte-wide register port.
 * Assumes the shared clk; strobes change only after a falling edge.
 */
module host_bus_model (
   // system
   input wire logic clk,
   // register port
   output logic csN,
   output logic rdN,
   output logic wrN,
   output logic [4:0] addr,
   output logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic dataOeN,
   // captured read data
   output logic [7:0] rdData,
   output logic rdValid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      csN = 1'b1;
      rdN = 1'b1;
      wrN = 1'b1;
      addr = 5'h00;
      dataIn = 8'h5A;
      rdValid = 1'b0;
   end

   // strobes last four cycles low and four high: the port syncs them
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      dataIn = d;
      csN = 1'b0;
      wrN = 1'b0;
      repeat (4) @(negedge clk);
      csN = 1'b1;
      wrN = 1'b1;
      // released data lines are not left showing the last byte
      dataIn = ~d;
      repeat (4) @(negedge clk);
   endtask

   task automatic rd(input logic [4:0] a);
      int n;
      @(negedge clk);
      addr = a;
      csN = 1'b0;
      rdN = 1'b0;
      n = 0;
      while (dataOeN !== 1'b0 && n < 8) begin
         @(negedge clk);
         n++;
      end
      rdData = dataOut;
      rdValid = 1'b1;
      @(negedge clk);
      rdValid = 1'b0;
      repeat (2) @(negedge clk);
      csN = 1'b1;
      rdN = 1'b1;
      repeat (4) @(negedge clk);
   endtask
endmodule // host_bus_model

// ==== tb/multimode_down_timer_monitor.sv ====
/*
 * Port checker for multimode_down_timer: bus answer timing, reset release
 * and pin drive. Bound to the top module from the testbench file.
 */
module multimode_down_timer_monitor
   import timer_pkg::*;
#(
   parameter int BaseCyc = BASE_CYC,
   parameter int MsCyc = MS_CYC
) (
   // system
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic csN,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic [7:0] dataOut,
   input wire logic dataOeN,
   // output pins
   input wire logic multifunction_output_pin,
   input wire logic multifunctionOeN,
   input wire logic second_timer_output_pin,
   input wire logic secondTimerOeN,
   input wire logic interrupt_pin,
   input wire logic interruptOeN
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence readStart;
      $fell(rdN) && !csN;
   endsequence
   sequence readIdle;
      rdN [*6];
   endsequence

   chk_read_answer: assert property (readStart |-> ##[2:5] !dataOeN)
      else $error("read data not driven in time");
   chk_read_release: assert property ($rose(rdN) |-> ##[2:5] dataOeN)
      else $error("data bus not released after read");
   chk_bus_idle: assert property (readIdle |-> dataOeN)
      else $error("data bus driven without a read");
   chk_write_quiet: assert property (!csN && !wrN && rdN |-> dataOeN)
      else $error("data bus driven during a write");
   // stopped timer0 and the interrupt pin show an inactive level once the drivers come up
   chk_reset_release: assert property ($rose(nrst) |-> multifunctionOeN
      && secondTimerOeN ##1 !multifunctionOeN && !multifunction_output_pin && !interrupt_pin)
      else $error("pins wrong after reset release");
   chk_mfo_drive: assert property (multifunctionOeN |-> !multifunction_output_pin)
      else $error("released timer0 pin carries a high value");
   chk_t1_drive: assert property (secondTimerOeN |-> !second_timer_output_pin)
      else $error("released timer1 pin carries a high value");
   chk_interrupt_pin_drive: assert property (interruptOeN |-> !interrupt_pin)
      else $error("released interrupt pin carries a high value");
endmodule // multimode_down_timer_monitor

// ==== tb/tb_multimode_down_timer.sv ====
/*
 * Testbench for multimode_down_timer: host model on the register port,
 * timer clocks and gates driven here. Assumes BaseCyc 8 and MsCyc 10.
 */
module tb_multimode_down_timer
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int EXT = 16;
   logic clk, nrst, csN, rdN, wrN, dataOeN, timerClkPin, xtalClkPin, rdValid;
   logic gate_pin_zero, gate_pin_one, mfoPin, mfoOeN, t1Pin, t1OeN, intPin, intOeN;
   logic [4:0] addr;
   logic [7:0] dataIn, dataOut, rdData, pre;
   logic [7:0] expQ[$];
   int mismatches, checks_done, hi, lo, n;
   int per[8] = '{16, 6, 24, 8, 10, 100, 1000, 10000};

   multimode_down_timer #(.BaseCyc(8), .MsCyc(10)) DUT (
      .clk(clk), .nrst(nrst), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr),
      .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
      .timerClkPin(timerClkPin), .xtalClkPin(xtalClkPin),
      .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one),
      .multifunction_output_pin(mfoPin), .multifunctionOeN(mfoOeN),
      .second_timer_output_pin(t1Pin), .secondTimerOeN(t1OeN),
      .interrupt_pin(intPin), .interruptOeN(intOeN));
   host_bus_model host (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(addr),
      .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .rdData(rdData),
      .rdValid(rdValid));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // timer clocks free-running, phase unrelated to clk
   initial begin
      timerClkPin = 1'b0;
      xtalClkPin = 1'b0;
      #7;
      fork
         forever #160 timerClkPin = ~timerClkPin;
         forever #60 xtalClkPin = ~xtalClkPin;
      join
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic logic [7:0] ctl(input logic [2:0] c, input logic [1:0] m, input logic r);
      return {2'b00, c, m, r};
   endfunction

   task automatic rdx(input logic [4:0] a, input logic [7:0] e);
      expQ.push_back(e);
      host.rd(a);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   // cycles high then low of timer0 pin, each wait capped at lim
   task automatic meas(input int lim);
      int w;
      // own counter: callers keep their n across a measurement
      w = 0;
      while (mfoPin !== 1'b1 && w < lim) begin
         cyc(1);
         w++;
      end
      hi = 0;
      while (mfoPin === 1'b1 && hi < lim) begin
         cyc(1);
         hi++;
      end
      lo = 0;
      while (mfoPin !== 1'b1 && lo < lim) begin
         cyc(1);
         lo++;
      end
   endtask

   task automatic start0(input logic [2:0] c, input logic [1:0] m);
      host.wr(ADDR_CTRL0, ctl(c, m, 1'b0));
      host.wr(ADDR_CTRL0, ctl(c, m, 1'b1));
   endtask

   always @(posedge clk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) begin
            mismatches++;
            $display("[FAIL] %0t read data with no expected value", $time);
         end else begin
            check(32'(rdData), 32'(expQ.pop_front()));
         end
      end
   end

   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   initial begin
      nrst = 1'b0;
      gate_pin_zero = 1'b0;
      gate_pin_one = 1'b0;
      mismatches = 0;
      checks_done = 0;
      n = $urandom(32'hFA050BF9);
      cyc(12);
      nrst = 1'b1;
      cyc(2);
      check(32'(mfoPin), 32'h0);
      rdx(ADDR_CTRL0, 8'h00);
      rdx(5'h1F, 8'h00);
      pre = 8'($urandom);
      host.wr(ADDR_T1_LO, pre);
      host.wr(ADDR_T1_HI, ~pre);
      rdx(ADDR_T1_LO, pre);
      rdx(ADDR_T1_HI, ~pre);
      host.wr(ADDR_T0_LO, 8'h01);
      host.wr(ADDR_T0_HI, 8'h00);
      for (int c = 0; c < 8; c++) begin
         start0(3'(c), MODE_RATE);
         meas(3 * per[c] + 64);
         check(32'(hi), 32'(per[c]));
         check(32'(lo), 32'(per[c]));
         host.wr(ADDR_CTRL0, ctl(3'(c), MODE_RATE, 1'b0));
      end
      rdx(ADDR_STATUS, 8'h01);
      n = 1 + ($urandom % 3);
      host.wr(ADDR_T0_LO, 8'(n));
      start0(CLK_EXT, MODE_SQUARE);
      meas(200);
      meas(200);
      check(32'(hi), 32'((n + 1) * EXT));
      check(32'(lo), 32'((n + 1) * EXT));
      host.wr(ADDR_T0_LO, 8'h02);
      start0(CLK_EXT, MODE_RATE);
      meas(200);
      gate_pin_zero = 1'b1;
      cyc(8);
      pre = {7'h00, mfoPin};
      n = 0;
      repeat (100) begin
         cyc(1);
         n += int'(mfoPin !== pre[0]);
      end
      check(32'(n), 32'h0);
      gate_pin_zero = 1'b0;
      meas(200);
      meas(200);
      check(32'(hi), 32'(2 * EXT));
      check(32'(lo), 32'(EXT));
      host.wr(ADDR_CTRL0, ctl(CLK_EXT, MODE_PULSE, 1'b0));
      host.wr(ADDR_STATUS, 8'h01);
      host.wr(ADDR_T0_LO, 8'h03);
      start0(CLK_EXT, MODE_PULSE);
      meas(200);
      check(32'(hi), 32'(3 * EXT));
      check(32'(lo), 32'd200);
      rdx(ADDR_CTRL0, ctl(CLK_EXT, MODE_PULSE, 1'b0));
      rdx(ADDR_STATUS, 8'h01);
      check(32'(intPin), 32'h0);
      host.wr(ADDR_CTRL0, 8'h40);
      rdx(ADDR_T0_LO, 8'h00);
      rdx(ADDR_T0_LO, 8'h03);
      host.wr(ADDR_STATUS, 8'h40);
      host.wr(ADDR_INTEN, 8'h01);
      host.wr(ADDR_OUTCFG, 8'h01);
      cyc(3);
      check(32'({mfoOeN, mfoPin}), 32'h1);
      host.wr(ADDR_OUTCFG, 8'h03);
      cyc(3);
      check(32'({mfoOeN, mfoPin}), 32'h2);
      host.wr(ADDR_OUTCFG, 8'h00);
      host.wr(ADDR_STATUS, 8'h00);
      host.wr(ADDR_ROUTE, 8'h01);
      cyc(3);
      check(32'(intPin), 32'h1);
      host.wr(ADDR_STATUS, 8'h01);
      cyc(3);
      check(32'(intPin), 32'h0);
      host.wr(ADDR_T1_LO, 8'h02);
      host.wr(ADDR_T1_HI, 8'h00);
      host.wr(ADDR_CTRL1, ctl(CLK_EXT, MODE_ONESHOT, 1'b0));
      host.wr(ADDR_CTRL1, ctl(CLK_EXT, MODE_ONESHOT, 1'b1));
      check(32'(t1Pin), 32'h0);
      gate_pin_one = 1'b1;
      cyc(6);
      check(32'(t1Pin), 32'h1);
      gate_pin_one = 1'b0;
      n = 0;
      while (t1Pin === 1'b1 && n < 80) begin
         cyc(1);
         n++;
      end
      check(32'(n >= 20 && n < 50), 32'h1);
      finish_test();
   end
endmodule // tb_multimode_down_timer

bind multimode_down_timer multimode_down_timer_monitor #(.BaseCyc(BaseCyc), .MsCyc(MsCyc)) mon (
   .clk(clk), .nrst(nrst), .csN(csN), .rdN(rdN), .wrN(wrN), .dataOut(dataOut),
   .dataOeN(dataOeN), .multifunction_output_pin(multifunction_output_pin),
   .multifunctionOeN(multifunctionOeN), .second_timer_output_pin(second_timer_output_pin),
   .secondTimerOeN(secondTimerOeN), .interrupt_pin(interrupt_pin),
   .interruptOeN(interruptOeN));

// ==== verilog/multimode_down_timer.sv ====
/*
 * Two 16-bit multimode down timers behind a byte-wide parallel port.
 * Assumes all pins are asynchronous to clk and strobes last >= 4 cycles.
 */
module multimode_down_timer
   import timer_pkg::*;
#(
   parameter int BaseCyc = BASE_CYC,
   parameter int MsCyc = MS_CYC
) (
   // system
   input wire logic clk,
   input wire logic nrst,
   // parallel register port
   input wire logic csN,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic [4:0] addr,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOeN,
   // timer clocks and gates
   input wire logic timerClkPin,
   input wire logic xtalClkPin,
   input wire logic gate_pin_zero,
   input wire logic gate_pin_one,
   // output pins
   output logic multifunction_output_pin,
   output logic multifunctionOeN,
   output logic second_timer_output_pin,
   output logic secondTimerOeN,
   output logic interrupt_pin,
   output logic interruptOeN
);
   localparam int SW = 20;

   // pin synchronisers: stage 1 read only by stage 2
   logic [SW-1:0] pinS1_q;
   logic [SW-1:0] pinS2_q;
   logic [3:0] edgeD_q;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pinS1_q <= {3'h7, 17'h0};
         pinS2_q <= {3'h7, 17'h0};
         edgeD_q <= 4'h0;
      end else begin
         pinS1_q <= {csN, rdN, wrN, addr, dataIn, gate_pin_one, gate_pin_zero,
            timerClkPin, xtalClkPin};
         pinS2_q <= pinS1_q;
         edgeD_q <= pinS2_q[3:0];
      end
   end
   wire csNS = pinS2_q[19];
   wire rdNS = pinS2_q[18];
   wire wrNS = pinS2_q[17];
   wire [4:0] addrS = pinS2_q[16:12];
   wire [7:0] dataS = pinS2_q[11:4];
   wire [1:0] gateS = pinS2_q[3:2];
   wire extFall = edgeD_q[1] & ~pinS2_q[1];
   wire xtalFall = edgeD_q[0] & ~pinS2_q[0];

   // bus strobes
   logic wrActD_q;
   logic rdActD_q;
   logic [4:0] rdAddr_q;
   wire wrAct = ~csNS & ~wrNS;
   wire rdAct = ~csNS & ~rdNS;
   wire wrGo = wrAct & ~wrActD_q;
   wire rdEnd = ~rdAct & rdActD_q;

   // registers
   logic [7:0] ctrl_q [2];
   logic [7:0] preLo_q [2];
   logic [7:0] preHi_q [2];
   logic [15:0] latch_q [2];
   logic [7:0] outCfg_q;
   logic [7:0] intEn_q;
   logic [7:0] route_q;
   logic [1:0] flag_q;
   logic rsel_q;
   logic psel_q;

   // timer state
   tstate_t st_q [2];
   logic [15:0] cnt_q [2];
   logic [1:0] out_q;
   logic [1:0] runClr;
   logic [1:0] irqEvt;

   // write decode
   wire page0 = ~psel_q;
   wire wrStat = wrGo && addrS == ADDR_STATUS;
   wire wrCtl0 = wrGo && page0 && !rsel_q && addrS == ADDR_CTRL0;
   wire wrCtl1 = wrGo && page0 && !rsel_q && addrS == ADDR_CTRL1;
   wire wrOcfg = wrGo && page0 && rsel_q && addrS == ADDR_OUTCFG;
   wire wrIen = wrGo && page0 && rsel_q && addrS == ADDR_INTEN;
   wire wrRte = wrGo && page0 && !rsel_q && addrS == ADDR_ROUTE;
   wire [1:0] wrCtl = {wrCtl1, wrCtl0};
   wire [1:0] wrLo = {wrGo && page0 && addrS == ADDR_T1_LO,
      wrGo && page0 && addrS == ADDR_T0_LO};
   wire [1:0] wrHi = {wrGo && page0 && addrS == ADDR_T1_HI,
      wrGo && page0 && addrS == ADDR_T0_HI};
   wire [1:0] rdLoEnd = {rdEnd && page0 && rdAddr_q == ADDR_T1_LO,
      rdEnd && page0 && rdAddr_q == ADDR_T0_LO};

   // read selection of one timer data byte
   function automatic logic [7:0] dataByte(input logic rdBit, input logic hi,
         input logic [15:0] lat, input logic [7:0] lo8, input logic [7:0] hi8);
      logic [7:0] r;
      r = 8'h00;
      if (rdBit) r = hi ? lat[15:8] : lat[7:0];
      else r = hi ? hi8 : lo8;
      return r;
   endfunction

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrActD_q <= 1'b0;
         rdActD_q <= 1'b0;
         rdAddr_q <= 5'h00;
      end else begin
         wrActD_q <= wrAct;
         rdActD_q <= rdAct;
         if (rdAct && !rdActD_q) rdAddr_q <= addrS;
      end
   end

   // status, config and routing registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         outCfg_q <= REG_RESET;
         intEn_q <= REG_RESET;
         route_q <= REG_RESET;
         rsel_q <= 1'b0;
         psel_q <= 1'b0;
         flag_q <= 2'h0;
      end else begin
         if (wrOcfg) outCfg_q <= dataS;
         if (wrIen) intEn_q <= dataS;
         if (wrRte) route_q <= dataS;
         if (wrStat) begin
            rsel_q <= dataS[STAT_RSEL];
            psel_q <= dataS[STAT_PSEL];
         end
         // a new event wins over a write-one clear
         flag_q <= (flag_q & ~({2{wrStat}} & dataS[STAT_FLAG1:STAT_FLAG0])) | irqEvt;
      end
   end

   // read data path, registered
   logic [7:0] rdMux;
   always_comb begin
      rdMux = 8'h00;
      if (addrS == ADDR_STATUS)
         rdMux = {psel_q, rsel_q, 4'h0, flag_q};
      else if (page0) begin
         unique case (addrS)
            ADDR_CTRL0: rdMux = rsel_q ? 8'h00 : ctrl_q[0];
            ADDR_CTRL1: rdMux = rsel_q ? outCfg_q : ctrl_q[1];
            ADDR_INTEN: rdMux = rsel_q ? intEn_q : 8'h00;
            ADDR_ROUTE: rdMux = rsel_q ? 8'h00 : route_q;
            ADDR_T0_LO: rdMux = dataByte(ctrl_q[0][CTL_READ], 1'b0, latch_q[0],
               preLo_q[0], preHi_q[0]);
            ADDR_T0_HI: rdMux = dataByte(ctrl_q[0][CTL_READ], 1'b1, latch_q[0],
               preLo_q[0], preHi_q[0]);
            ADDR_T1_LO: rdMux = dataByte(ctrl_q[1][CTL_READ], 1'b0, latch_q[1],
               preLo_q[1], preHi_q[1]);
            ADDR_T1_HI: rdMux = dataByte(ctrl_q[1][CTL_READ], 1'b1, latch_q[1],
               preLo_q[1], preHi_q[1]);
            default: rdMux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dataOut <= 8'h00;
         dataOeN <= 1'b1;
      end else begin
         dataOeN <= ~rdAct;
         if (rdAct) dataOut <= rdMux;
      end
   end

   // timer interrupts reach the pin only if enabled and routed
   wire intActive = |(flag_q & intEn_q[1:0]) & route_q[RT_TIMER];

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_tmr
         prescaler_if pif ();
         timer_prescaler #(
            .BaseCyc(BaseCyc),
            .MsCyc(MsCyc)
         ) u_presc (
            .clk(clk),
            .nrst(nrst),
            .p(pif.presc)
         );

         wire run = ctrl_q[i][CTL_RUN];
         wire [1:0] mode = ctrl_q[i][CTL_MODE_HI:CTL_MODE_LO];
         wire oneShot = mode == MODE_ONESHOT;
         wire hold = gateS[i] | ctrl_q[i][CTL_HOLD];
         logic holdD_q;
         wire trigRise = oneShot & hold & ~holdD_q;
         wire resume = ~oneShot & holdD_q & ~hold;
         wire start = st_q[i] == ST_IDLE && run;
         // count only on the selected edge; hold stops counting except in one-shot mode
         wire step = pif.tick & (oneShot | ~hold);
         wire atZero = cnt_q[i] <= 16'h0001;
         wire zeroHit = st_q[i] == ST_COUNT && step && atZero && !trigRise;

         assign pif.sel = ctrl_q[i][CTL_CLK_HI:CTL_CLK_LO];
         assign pif.restart = start | resume;
         assign pif.extFall = extFall;
         assign pif.xtalFall = xtalFall;
         assign runClr[i] = zeroHit && mode == MODE_PULSE;
         // square wave interrupts only on the high-to-low toggle
         assign irqEvt[i] = zeroHit && (mode != MODE_SQUARE || out_q[i]);

         always_ff @(posedge clk) begin
            if (!nrst) holdD_q <= 1'b0;
            else holdD_q <= hold;
         end

         // control, preset and latch registers; software write wins
         always_ff @(posedge clk) begin
            if (!nrst) begin
               ctrl_q[i] <= REG_RESET;
               preLo_q[i] <= REG_RESET;
               preHi_q[i] <= REG_RESET;
               latch_q[i] <= 16'h0000;
            end else begin
               if (wrCtl[i]) ctrl_q[i] <= dataS;
               else begin
                  if (runClr[i]) ctrl_q[i][CTL_RUN] <= 1'b0;
                  if (rdLoEnd[i]) ctrl_q[i][CTL_READ] <= 1'b0;
               end
               if (wrCtl[i] && dataS[CTL_READ]) latch_q[i] <= cnt_q[i];
               if (wrLo[i]) preLo_q[i] <= dataS;
               if (wrHi[i]) preHi_q[i] <= dataS;
            end
         end

         // counter and output sequencer
         always_ff @(posedge clk) begin
            if (!nrst) begin
               st_q[i] <= ST_IDLE;
               cnt_q[i] <= 16'h0000;
               out_q[i] <= 1'b0;
            end else if (!run) begin
               st_q[i] <= ST_IDLE;
               out_q[i] <= 1'b0;
            end else begin
               unique case (st_q[i])
                  ST_IDLE: st_q[i] <= ST_ARM;
                  ST_ARM: begin
                     if (oneShot) begin
                        if (trigRise) begin
                           out_q[i] <= 1'b1;
                           st_q[i] <= ST_LOAD;
                        end
                     end else if (step) begin
                        cnt_q[i] <= {preHi_q[i], preLo_q[i]};
                        out_q[i] <= 1'b1;
                        st_q[i] <= ST_COUNT;
                     end
                  end
                  ST_LOAD: begin
                     if (oneShot && trigRise) st_q[i] <= ST_LOAD;
                     else if (step) begin
                        cnt_q[i] <= {preHi_q[i], preLo_q[i]};
                        if (mode == MODE_RATE) out_q[i] <= 1'b1;
                        st_q[i] <= ST_COUNT;
                     end
                  end
                  ST_COUNT: begin
                     if (trigRise) st_q[i] <= ST_LOAD;
                     else if (step) begin
                        if (atZero) begin
                           cnt_q[i] <= 16'h0000;
                           unique case (mode)
                              MODE_PULSE: begin
                                 out_q[i] <= 1'b0;
                                 st_q[i] <= ST_IDLE;
                              end
                              MODE_RATE: begin
                                 out_q[i] <= 1'b0;
                                 st_q[i] <= ST_LOAD;
                              end
                              MODE_SQUARE: begin
                                 out_q[i] <= ~out_q[i];
                                 st_q[i] <= ST_LOAD;
                              end
                              MODE_ONESHOT: begin
                                 out_q[i] <= 1'b0;
                                 st_q[i] <= ST_ARM;
                              end
                           endcase
                        end else cnt_q[i] <= cnt_q[i] - 16'h0001;
                     end
                  end
                  default: st_q[i] <= ST_IDLE;
               endcase
            end
         end
      end
   endgenerate

   // pin drivers: polarity, then push-pull or open drain
   wire lvl0 = out_q[0] ^ outCfg_q[OC_INV0];
   wire lvl1 = out_q[1] ^ outCfg_q[OC_INV1];
   wire lvlI = intActive ^ outCfg_q[OC_INVI];
   always_ff @(posedge clk) begin
      if (!nrst) begin
         multifunction_output_pin <= 1'b0;
         multifunctionOeN <= 1'b1;
         second_timer_output_pin <= 1'b0;
         secondTimerOeN <= 1'b1;
         interrupt_pin <= 1'b0;
         interruptOeN <= 1'b1;
      end else begin
         // open drain only sinks, so it drives when the level is low
         multifunction_output_pin <= outCfg_q[OC_OD0] ? 1'b0 : lvl0;
         multifunctionOeN <= outCfg_q[OC_OD0] & lvl0;
         second_timer_output_pin <= outCfg_q[OC_OD1] ? 1'b0 : lvl1;
         secondTimerOeN <= outCfg_q[OC_OD1] & lvl1;
         interrupt_pin <= outCfg_q[OC_ODI] ? 1'b0 : lvlI;
         interruptOeN <= outCfg_q[OC_ODI] & lvlI;
      end
   end
endmodule // multimode_down_timer

// ==== verilog/timer_prescaler.sv ====
/*
 * Per-timer prescaler: picks one of eight timer clocks, gives a one-cycle
 * tick on each falling edge of it. Assumes one clk and pre-synced edges.
 */
module timer_prescaler
   import timer_pkg::*;
#(
   parameter int BaseCyc = BASE_CYC,
   parameter int MsCyc = MS_CYC
) (
   // system
   input wire logic clk,
   input wire logic nrst,
   // channel side
   prescaler_if.presc p
);
   localparam int BW = $clog2(BaseCyc);
   localparam int MW = $clog2(MsCyc);
   logic [BW-1:0] baseCnt_q;
   logic [MW-1:0] msCnt_q;
   logic [3:0] d10_q;
   logic [3:0] d100_q;
   logic [3:0] d1s_q;
   logic [1:0] xDiv_q;
   wire baseEnd = baseCnt_q == BW'(BaseCyc - 1);
   wire msEnd = msCnt_q == MW'(MsCyc - 1);
   wire end10 = msEnd && d10_q == DECADE_LAST;
   wire end100 = end10 && d100_q == DECADE_LAST;
   wire end1s = end100 && d1s_q == DECADE_LAST;
   wire x4End = p.xtalFall && xDiv_q == 2'h3;

   // restart zeroes every time-base stage but not xDiv_q, so start error stays under one period
   always_ff @(posedge clk) begin
      if (!nrst || p.restart) begin
         baseCnt_q <= '0;
         msCnt_q <= '0;
         d10_q <= '0;
         d100_q <= '0;
         d1s_q <= '0;
      end else begin
         baseCnt_q <= baseEnd ? '0 : baseCnt_q + 1'b1;
         msCnt_q <= msEnd ? '0 : msCnt_q + 1'b1;
         if (msEnd) d10_q <= end10 ? 4'h0 : d10_q + 4'h1;
         if (end10) d100_q <= end100 ? 4'h0 : d100_q + 4'h1;
         if (end100) d1s_q <= end1s ? 4'h0 : d1s_q + 4'h1;
      end
   end

   // crystal divided by four still follows the crystal pin
   always_ff @(posedge clk) begin
      if (!nrst) xDiv_q <= 2'h0;
      else if (p.xtalFall) xDiv_q <= xDiv_q + 2'h1;
   end

   // eight-way clock choice
   always_comb begin
      unique case (p.sel)
         CLK_EXT: p.tick = p.extFall;
         CLK_XTAL: p.tick = p.xtalFall;
         CLK_XTAL4: p.tick = x4End;
         CLK_10K7: p.tick = baseEnd;
         CLK_1K: p.tick = msEnd;
         CLK_100: p.tick = end10;
         CLK_10: p.tick = end100;
         CLK_1: p.tick = end1s;
      endcase
   end
endmodule // timer_prescaler
